// ### verilog/lpd_cfg.svh
`ifndef LPD_CFG_SVH
`define LPD_CFG_SVH

// identifier of the two-motor long form (parity bits are zero for it)
`define LPD_ID_MULTI 6'h3c
// application opcode prefix carried in data byte 1 of the 0x3c form
`define LPD_APP_PREFIX 8'h80
// move_absolute_cmd opcode with bit 7 set
`define LPD_OPC_MOVE 8'h8b
// identifier bits 5..4 of four-data-byte frames
`define LPD_ID_LEN4 2'b10
// rom pointer that a general-purpose four-byte frame must be allocated to
`define LPD_GP4_ROM_PTR 4'h1
// microstep_resolution code for half stepping
`define LPD_STEP_HALF 2'b00
// nonvolatile byte holding otp_station_bits
`define LPD_OTP_PA_ADDR 8'h02
// most data bytes in a frame
`define LPD_MAX_DATA 8
// data byte counts of the decoded forms
`define LPD_LEN2 4'h2
`define LPD_LEN4 4'h4
`define LPD_LEN8 4'h8

`endif

// ### verilog/lpd_pkg.sv
package lpd_pkg;

  typedef logic [7:0] lpd_byte_t;

  typedef enum logic [1:0] {
    LPD_RX_IDLE = 2'b00,
    LPD_RX_DATA = 2'b01,
    LPD_RX_EVAL = 2'b11
  } lpd_rx_state_t;

  typedef enum logic [1:0] {
    LPD_TX_IDLE = 2'b00,
    LPD_TX_ID = 2'b01,
    LPD_TX_DATA = 2'b11,
    LPD_TX_CKS = 2'b10
  } lpd_tx_state_t;

  // protected identifier: bit 6 even parity, bit 7 odd parity
  function automatic lpd_byte_t lpd_protect(input logic [5:0] id);
    logic p0;
    logic p1;
    p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
    p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    return {p1, p0, id};
  endfunction

  // classic checksum step: add with end-around carry
  function automatic lpd_byte_t lpd_cks_add(input lpd_byte_t a, input lpd_byte_t b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0] + {7'h00, s[8]};
  endfunction

endpackage

// ### verilog/lpd_link_if.sv
`timescale 1ns/1ps
interface lpd_link_if (
  input wire logic mclk, // shared clock
  input wire logic rst   // shared reset
);
  logic byte_valid;
  logic byte_first;
  logic byte_last;
  logic [7:0] byte_data;

  modport master (output byte_valid, output byte_first, output byte_last, output byte_data);
  modport node (input byte_valid, input byte_first, input byte_last, input byte_data);
endinterface

// ### verilog/lpd_node.sv
`timescale 1ns/1ps
`include "lpd_cfg.svh"

// Behaviour
// - two-byte direct frame moves own motor
// - direct frame: id bit5 zero, pos high-low
// - caller of the master gives each motor a direct identifier
// - four-byte general frame uses rom pointer 0001
// - general frame: opcode 0x0b, broadcast, station, position
// - general broadcast moves every node
// - 0x3c frame: prefix 0x80, opcode, two motor pairs
// - long-form targets are signed sixteen bits
// - 0x3c pair chosen by seven-bit station match
// - compact command moves one or two motors
// - compact command only in half stepping
// - compact station is four bits, sixteen nodes
// - compact station compared with otp station bits
// - master ties hard-wired address bits high
// - compact one-motor frame field layout
// - compact one-motor broadcast moves every node
// - compact two-motor frame field layout
// - compact targets are signed eleven bits
// - master supplies identifier parity bits
module lpd_node
  import lpd_pkg::*;
#(
  parameter int MAX_DATA = `LPD_MAX_DATA
) (
  input wire logic mclk,                     // system clock
  input wire logic rst,                      // async reset, active high
  lpd_link_if.node link,                     // frame bytes from the master
  input wire logic [6:0] station_address,    // node physical address
  input wire logic [3:0] otp_station_bits,   // low address bits from otp byte
  input wire logic [1:0] microstep_resolution, // current stepping mode
  input wire logic [5:0] direct_pos_id,      // id allocated to the direct form
  input wire logic [5:0] gp4_id,             // id allocated to rom pointer 0001
  input wire logic [5:0] compact1_id,        // id of the compact one-motor form
  input wire logic [5:0] compact2_id,        // id of the compact two-motor form
  output logic move_valid,                   // pulse: new absolute target
  output logic [15:0] move_target,           // signed target set-point
  output logic move_compact,                 // target came from compact form
  output logic frame_reject                  // pulse: parity/checksum/length fault
);

  lpd_rx_state_t st_q, st_d;
  lpd_byte_t id_q, id_d;
  lpd_byte_t cks_q, cks_d;
  lpd_byte_t chk_q, chk_d;
  lpd_byte_t buf_q [MAX_DATA];
  lpd_byte_t buf_d [MAX_DATA];
  logic [3:0] cnt_q, cnt_d;
  logic ovf_q, ovf_d;

  logic mv_q, mv_d;
  logic [15:0] tgt_q, tgt_d;
  logic cmp_q, cmp_d;
  logic rej_q, rej_d;

  assign move_valid = mv_q;
  assign move_target = tgt_q;
  assign move_compact = cmp_q;
  assign frame_reject = rej_q;

  // frame collection
  always_comb
  begin
    st_d = st_q;
    id_d = id_q;
    cks_d = cks_q;
    chk_d = chk_q;
    buf_d = buf_q;
    cnt_d = cnt_q;
    ovf_d = ovf_q;
    // a new identifier always restarts, so a cut frame cannot poison the next
    if (link.byte_valid && link.byte_first)
    begin
      id_d = link.byte_data;
      cks_d = 8'h00;
      cnt_d = 4'h0;
      ovf_d = 1'b0;
      st_d = LPD_RX_DATA;
    end
    else
    begin
      case (st_q)
        LPD_RX_IDLE:
        begin
          st_d = LPD_RX_IDLE;
        end
        LPD_RX_DATA:
        begin
          if (link.byte_valid && link.byte_last)
          begin
            chk_d = link.byte_data;
            st_d = LPD_RX_EVAL;
          end
          else if (link.byte_valid)
          begin
            if (cnt_q == 4'(MAX_DATA))
            begin
              ovf_d = 1'b1;
            end
            else
            begin
              buf_d[cnt_q[2:0]] = link.byte_data;
              cnt_d = cnt_q + 4'h1;
              cks_d = lpd_cks_add(cks_q, link.byte_data);
            end
          end
        end
        LPD_RX_EVAL:
        begin
          st_d = LPD_RX_IDLE;
        end
        default:
        begin
          st_d = LPD_RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= LPD_RX_IDLE;
      id_q <= 8'h00;
      cks_q <= 8'h00;
      chk_q <= 8'h00;
      cnt_q <= 4'h0;
      ovf_q <= 1'b0;
      for (int i = 0; i < MAX_DATA; i++)
      begin
        buf_q[i] <= 8'h00;
      end
    end
    else
    begin
      st_q <= st_d;
      id_q <= id_d;
      cks_q <= cks_d;
      chk_q <= chk_d;
      cnt_q <= cnt_d;
      ovf_q <= ovf_d;
      buf_q <= buf_d;
    end
  end

  // decode of the collected frame
  logic [5:0] fid;
  logic frame_ok;
  logic half_step;
  assign fid = id_q[5:0];
  assign half_step = (microstep_resolution == `LPD_STEP_HALF);
  assign frame_ok = (id_q == lpd_protect(fid)) && (chk_q == ~cks_q) && !ovf_q;

  always_comb
  begin
    mv_d = 1'b0;
    tgt_d = tgt_q;
    cmp_d = cmp_q;
    rej_d = 1'b0;
    if (st_q == LPD_RX_EVAL)
    begin
      if (!frame_ok)
      begin
        rej_d = 1'b1;
      end
      else if (fid == `LPD_ID_MULTI && cnt_q == `LPD_LEN8)
      begin
        if (buf_q[0] == `LPD_APP_PREFIX && buf_q[1] == `LPD_OPC_MOVE)
        begin
          // first pair wins when both station fields carry this address
          if (buf_q[2][7] && buf_q[2][6:0] == station_address)
          begin
            mv_d = 1'b1;
            tgt_d = {buf_q[3], buf_q[4]};
            cmp_d = 1'b0;
          end
          else if (buf_q[5][7] && buf_q[5][6:0] == station_address)
          begin
            mv_d = 1'b1;
            tgt_d = {buf_q[6], buf_q[7]};
            cmp_d = 1'b0;
          end
        end
      end
      else if (fid == direct_pos_id && !fid[5] && cnt_q == `LPD_LEN2)
      begin
        mv_d = 1'b1;
        tgt_d = {buf_q[0], buf_q[1]};
        cmp_d = 1'b0;
      end
      else if (fid == gp4_id && fid[5:4] == `LPD_ID_LEN4 && cnt_q == `LPD_LEN4)
      begin
        if (buf_q[0] == `LPD_OPC_MOVE &&
            (!buf_q[1][7] || buf_q[1][6:0] == station_address))
        begin
          mv_d = 1'b1;
          tgt_d = {buf_q[2], buf_q[3]};
          cmp_d = 1'b0;
        end
      end
      else if (fid == compact1_id && !fid[5] && cnt_q == `LPD_LEN2 && half_step)
      begin
        if (!buf_q[0][4] || buf_q[0][3:0] == otp_station_bits)
        begin
          mv_d = 1'b1;
          tgt_d = {{5{buf_q[0][7]}}, buf_q[0][7:5], buf_q[1]};
          cmp_d = 1'b1;
        end
      end
      else if (fid == compact2_id && fid[5:4] == `LPD_ID_LEN4 && cnt_q == `LPD_LEN4 &&
               half_step && buf_q[0][4] && buf_q[2][4])
      begin
        // four-bit station fields only, so at most sixteen nodes
        if (buf_q[0][3:0] == otp_station_bits)
        begin
          mv_d = 1'b1;
          tgt_d = {{5{buf_q[0][7]}}, buf_q[0][7:5], buf_q[1]};
          cmp_d = 1'b1;
        end
        else if (buf_q[2][3:0] == otp_station_bits)
        begin
          mv_d = 1'b1;
          tgt_d = {{5{buf_q[2][7]}}, buf_q[2][7:5], buf_q[3]};
          cmp_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      mv_q <= 1'b0;
      tgt_q <= 16'h0000;
      cmp_q <= 1'b0;
      rej_q <= 1'b0;
    end
    else
    begin
      mv_q <= mv_d;
      tgt_q <= tgt_d;
      cmp_q <= cmp_d;
      rej_q <= rej_d;
    end
  end

endmodule // lpd_node

// ### verilog/lpd_master.sv
`timescale 1ns/1ps
`include "lpd_cfg.svh"

module lpd_master
  import lpd_pkg::*;
#(
  parameter int MAX_DATA = `LPD_MAX_DATA
) (
  input wire logic mclk,                    // system clock
  input wire logic rst,                     // async reset, active high
  lpd_link_if.master link,                  // frame bytes to the nodes
  input wire logic cmd_valid,               // request to send a frame
  output logic cmd_ready,                   // master idle, request taken
  input wire logic [5:0] cmd_id,            // unprotected identifier
  input wire logic [3:0] cmd_len,           // data byte count, 1..8
  input wire logic [63:0] cmd_data,         // data byte k in bits 8k+7..8k
  output logic hard_wired_address_bit0,     // strap level for the node
  output logic hard_wired_address_bit1,     // strap level for the node
  output logic hard_wired_address_bit2      // strap level for the node
);

  lpd_tx_state_t st_q, st_d;
  logic [63:0] sh_q, sh_d;
  logic [3:0] left_q, left_d;
  lpd_byte_t cks_q, cks_d;
  logic vld_q, vld_d;
  logic fst_q, fst_d;
  logic lst_q, lst_d;
  lpd_byte_t dat_q, dat_d;

  assign cmd_ready = (st_q == LPD_TX_IDLE);
  // recommended strap for networks using the compact command
  assign hard_wired_address_bit0 = 1'b1;
  assign hard_wired_address_bit1 = 1'b1;
  assign hard_wired_address_bit2 = 1'b1;
  assign link.byte_valid = vld_q;
  assign link.byte_first = fst_q;
  assign link.byte_last = lst_q;
  assign link.byte_data = dat_q;

  // the caller owns identifier allocation, one direct id per motor
  // four-byte general frames must use ids allocated to pointer 0001
  always_comb
  begin
    st_d = st_q;
    sh_d = sh_q;
    left_d = left_q;
    cks_d = cks_q;
    vld_d = 1'b0;
    fst_d = 1'b0;
    lst_d = 1'b0;
    dat_d = dat_q;
    case (st_q)
      LPD_TX_IDLE:
      begin
        // zero-length or oversized requests are dropped, not sent
        if (cmd_valid && cmd_len != 4'h0 && cmd_len <= 4'(MAX_DATA))
        begin
          vld_d = 1'b1;
          fst_d = 1'b1;
          dat_d = lpd_protect(cmd_id);
          sh_d = cmd_data;
          left_d = cmd_len;
          cks_d = 8'h00;
          st_d = LPD_TX_DATA;
        end
      end
      LPD_TX_DATA:
      begin
        vld_d = 1'b1;
        dat_d = sh_q[7:0];
        cks_d = lpd_cks_add(cks_q, sh_q[7:0]);
        sh_d = {8'h00, sh_q[63:8]};
        left_d = left_q - 4'h1;
        if (left_q == 4'h1)
        begin
          st_d = LPD_TX_CKS;
        end
      end
      LPD_TX_CKS:
      begin
        vld_d = 1'b1;
        lst_d = 1'b1;
        dat_d = ~cks_q;
        st_d = LPD_TX_IDLE;
      end
      LPD_TX_ID:
      begin
        st_d = LPD_TX_IDLE;
      end
      default:
      begin
        st_d = LPD_TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= LPD_TX_IDLE;
      sh_q <= 64'h0;
      left_q <= 4'h0;
      cks_q <= 8'h00;
      vld_q <= 1'b0;
      fst_q <= 1'b0;
      lst_q <= 1'b0;
      dat_q <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      sh_q <= sh_d;
      left_q <= left_d;
      cks_q <= cks_d;
      vld_q <= vld_d;
      fst_q <= fst_d;
      lst_q <= lst_d;
      dat_q <= dat_d;
    end
  end

endmodule // lpd_master

// ### verif/lpd_link_assertions.sv
`timescale 1ns/1ps
module lpd_link_assertions (
  input wire logic mclk, // shared clock
  input wire logic rst, // async reset
  input wire logic byte_valid, // byte strobe
  input wire logic byte_first, // identifier marker
  input wire logic byte_last, // checksum marker
  input wire logic [7:0] byte_data // byte value
);
  logic [7:0] acc_q;
  logic [7:0] acc_d;
  logic [8:0] sum;
  // running end-around-carry sum of the data bytes of the current frame
  always_comb
  begin
    sum = {1'b0, acc_q} + {1'b0, byte_data};
    acc_d = acc_q;
    if (byte_valid && byte_first)
    begin
      acc_d = 8'h00;
    end
    else if (byte_valid && !byte_last)
    begin
      acc_d = sum[7:0] + {7'h00, sum[8]};
    end
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      acc_q <= 8'h00;
    end
    else
    begin
      acc_q <= acc_d;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  chk_first_with_valid: assert property (byte_first |-> byte_valid && !byte_last)
    else $error("identifier marker without a lone strobe");
  chk_last_with_valid: assert property (byte_last |-> byte_valid)
    else $error("checksum marker without strobe");
  chk_parity_low: assert property (byte_valid && byte_first |->
    byte_data[6] == (byte_data[0] ^ byte_data[1] ^ byte_data[2] ^ byte_data[4]))
    else $error("identifier bit 6 parity wrong");
  chk_parity_high: assert property (byte_valid && byte_first |->
    byte_data[7] == !(byte_data[1] ^ byte_data[3] ^ byte_data[4] ^ byte_data[5]))
    else $error("identifier bit 7 parity wrong");
  chk_checksum_value: assert property (byte_valid && byte_last |-> byte_data == ~acc_q)
    else $error("checksum byte wrong");
  chk_frame_length: assert property (byte_valid && byte_first |->
    ##[2:9] (byte_valid && byte_last))
    else $error("frame length outside one to eight data bytes");
  chk_bytes_contiguous: assert property (byte_valid && !byte_last |=>
    byte_valid && !byte_first)
    else $error("gap or restart inside a frame");
  chk_after_last: assert property (byte_valid && byte_last |=> !byte_valid || byte_first)
    else $error("stray byte after checksum");
endmodule // lpd_link_assertions

// ### verif/tb_lin_position_command_decoder.sv
`timescale 1ns/1ps
module tb_lin_position_command_decoder
  import lpd_pkg::*;
;
  logic mclk;
  logic rst;
  logic cmd_valid;
  logic cmd_ready;
  logic [5:0] cmd_id;
  logic [3:0] cmd_len;
  logic [63:0] cmd_data;
  logic [2:0] hw;
  logic [1:0] microstep_resolution;
  logic [6:0] station_address;
  logic [3:0] otp_station_bits;
  logic [5:0] direct_pos_id;
  logic [5:0] gp4_id;
  logic [5:0] compact1_id;
  logic [5:0] compact2_id;
  logic move_valid, move_compact, frame_reject;
  logic move_valid_b, move_compact_b, frame_reject_b;
  logic [15:0] move_target, move_target_b;
  int bad_count;
  int samples_checked;

  lpd_link_if u_lpd_link_if (.mclk(mclk), .rst(rst));
  lpd_link_if u_lpd_link_if_b (.mclk(mclk), .rst(rst));
  lpd_master u_lpd_master (.mclk(mclk), .rst(rst), .link(u_lpd_link_if.master),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_id(cmd_id), .cmd_len(cmd_len),
    .cmd_data(cmd_data), .hard_wired_address_bit0(hw[0]), .hard_wired_address_bit1(hw[1]),
    .hard_wired_address_bit2(hw[2]));
  lpd_node u_lpd_node (.mclk(mclk), .rst(rst), .link(u_lpd_link_if.node),
    .station_address(station_address), .otp_station_bits(otp_station_bits),
    .microstep_resolution(microstep_resolution), .direct_pos_id(direct_pos_id),
    .gp4_id(gp4_id), .compact1_id(compact1_id), .compact2_id(compact2_id),
    .move_valid(move_valid),
    .move_target(move_target), .move_compact(move_compact), .frame_reject(frame_reject));
  // second node faces the bench directly so faulty frames can be injected
  lpd_node u_lpd_node_b (.mclk(mclk), .rst(rst), .link(u_lpd_link_if_b.node),
    .station_address(station_address), .otp_station_bits(otp_station_bits),
    .microstep_resolution(microstep_resolution), .direct_pos_id(direct_pos_id),
    .gp4_id(gp4_id), .compact1_id(compact1_id), .compact2_id(compact2_id),
    .move_valid(move_valid_b),
    .move_target(move_target_b), .move_compact(move_compact_b), .frame_reject(frame_reject_b));
  lpd_link_assertions u_lpd_link_assertions (.mclk(mclk), .rst(rst),
    .byte_valid(u_lpd_link_if.byte_valid), .byte_first(u_lpd_link_if.byte_first),
    .byte_last(u_lpd_link_if.byte_last), .byte_data(u_lpd_link_if.byte_data));

  always #50 mclk = ~mclk;

  task results();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // wait a bounded span for a move or reject pulse of node a or node b
  task wait_out(input bit b, output logic mv, output logic rj, output logic [15:0] t,
    output logic c);
    mv = 1'b0;
    rj = 1'b0;
    t = 16'h0000;
    c = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      @(negedge mclk);
      mv = b ? move_valid_b : move_valid;
      rj = b ? frame_reject_b : frame_reject;
      t = b ? move_target_b : move_target;
      c = b ? move_compact_b : move_compact;
      if (mv === 1'b1 || rj === 1'b1)
        break;
    end
  endtask

  task run(input logic [5:0] id, input logic [3:0] len, input logic [63:0] d,
    input logic ev, input logic [15:0] et, input logic ec);
    logic mv, rj, c;
    logic [15:0] t;
    @(negedge mclk);
    cmd_id = id;
    cmd_len = len;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    cmd_valid = 1'b0;
    wait_out(0, mv, rj, t, c);
    chk("move", {15'h0000, mv}, {15'h0000, ev});
    chk("reject", {15'h0000, rj}, 16'h0000);
    if (ev)
    begin
      chk("target", t, et);
      chk("compact", {15'h0000, c}, {15'h0000, ec});
    end
  endtask

  // data bytes past the second are zero, so the checksum stays that of 12 34
  task raw(input logic [7:0] id, input logic [3:0] n, input logic [7:0] cks, input logic ev,
    input logic er);
    logic mv, rj, c;
    logic [15:0] t;
    @(negedge mclk);
    u_lpd_link_if_b.byte_valid = 1'b1;
    u_lpd_link_if_b.byte_first = 1'b1;
    u_lpd_link_if_b.byte_data = id;
    @(negedge mclk);
    u_lpd_link_if_b.byte_first = 1'b0;
    u_lpd_link_if_b.byte_data = 8'h12;
    @(negedge mclk);
    u_lpd_link_if_b.byte_data = 8'h34;
    for (int i = 2; i < n; i++)
    begin
      @(negedge mclk);
      u_lpd_link_if_b.byte_data = 8'h00;
    end
    @(negedge mclk);
    u_lpd_link_if_b.byte_last = 1'b1;
    u_lpd_link_if_b.byte_data = cks;
    @(negedge mclk);
    u_lpd_link_if_b.byte_valid = 1'b0;
    u_lpd_link_if_b.byte_last = 1'b0;
    u_lpd_link_if_b.byte_data = ~cks;
    wait_out(1, mv, rj, t, c);
    chk("move_b", {15'h0000, mv}, {15'h0000, ev});
    chk("reject_b", {15'h0000, rj}, {15'h0000, er});
    if (ev)
      chk("target_b", t, 16'h1234);
  endtask

  task t_long();
    run(6'h05, 4'h2, 64'h0580, 1, 16'h8005, 0);
    run(6'h21, 4'h4, 64'h34127f8b, 1, 16'h1234, 0);
    run(6'h21, 4'h4, 64'h3412968b, 0, 16'h0000, 0);
    station_address = 7'h16;
    run(6'h21, 4'h4, 64'h3412968b, 1, 16'h1234, 0);
    station_address = 7'h15;
    run(6'h21, 4'h4, 64'hfeff958b, 1, 16'hfffe, 0);
    run(6'h3c, 4'h8, 64'hcdab951111918b80, 1, 16'habcd, 0);
    $display("done long forms");
  endtask

  task t_compact();
    run(6'h07, 4'h2, 64'h67b5, 1, 16'hfd67, 1);
    run(6'h07, 4'h2, 64'h1023, 1, 16'h0110, 1);
    run(6'h23, 4'h4, 64'h21754419, 1, 16'h0321, 1);
    otp_station_bits = 4'h9;
    run(6'h23, 4'h4, 64'h21754419, 1, 16'h0044, 1);
    otp_station_bits = 4'h5;
    microstep_resolution = 2'b01;
    run(6'h07, 4'h2, 64'h67b5, 0, 16'h0000, 0);
    microstep_resolution = 2'b00;
    chk("straps", {13'h0000, hw}, 16'h0007);
    $display("done compact forms");
  endtask

  task t_fault();
    raw(8'h85, 4'h2, 8'hb9, 1, 0);
    raw(8'h85, 4'h2, 8'hb8, 0, 1);
    raw(8'hc5, 4'h2, 8'hb9, 0, 1);
    raw(8'h85, 4'h9, 8'hb9, 0, 1);
    $display("done faulty frames");
  endtask

  initial
  begin
    #200000;
    bad_count++;
    results();
  end

  initial
  begin
    mclk = 1'b0;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_id = 6'h00;
    cmd_len = 4'h0;
    cmd_data = 64'h0;
    microstep_resolution = 2'b00;
    station_address = 7'h15;
    otp_station_bits = 4'h5;
    direct_pos_id = 6'h05;
    gp4_id = 6'h21;
    compact1_id = 6'h07;
    compact2_id = 6'h23;
    u_lpd_link_if_b.byte_valid = 1'b0;
    u_lpd_link_if_b.byte_first = 1'b0;
    u_lpd_link_if_b.byte_last = 1'b0;
    u_lpd_link_if_b.byte_data = 8'h00;
    bad_count = 0;
    samples_checked = 0;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    t_long();
    t_compact();
    t_fault();
    results();
  end
endmodule // tb_lin_position_command_decoder
